// file: logic/backplane_bus_control.sv
// processor-module side of the backplane: release, clock stretch, wait exit, standby
//
// How it works
// [R1] bus_released stays low in normal running, high only when stopped and bus free
// [R2] run/halt pin low halts the processor and raises bus_released
// [R3] entering the wait state also raises bus_released
// [R4] while released all address and data drivers are off, address_valid low
// [R5] wait state ends on accepted maskable interrupt, restart or abort
// [R6] ready low holds phase two high and stops new phase cycles
// [R7] a slow memory pulls ready low and releases it when done
// [R8] only the refresh master module drives the refresh trigger line
// [R9] refresh slaves start a refresh on the master's trigger
// [R10] standby line low during power fail, high otherwise; the logic also holds it low in reset
// [R11] data lines are two-way: driven on writes, sampled on reads
// [R12] plug-in modules drive data only when selected for a read; slow_mem always drives it: read data until three cycles after phase two, else a pattern
// [R13] tristate request floats address, forces address_valid and bus_released low
// [R14] maskable interrupt taken only with mask bit clear: at instruction end when running, at once in the wait state
// [R15] ready sampled each cycle; phase one follows the first cycle it is high
`timescale 1ns/1ps
module backplane_bus_control
    import bus_ctl_pkg::*;
#(
    parameter int DEPTH = bus_ctl_pkg::FIFO_DEPTH // request queue depth
) (
    input wire logic clock, // 50 MHz system clock
    input wire logic rstn, // asynchronous reset, active low
    input wire logic req_valid, // core offers a bus access
    input wire bus_ctl_pkg::bus_req_t req, // the access
    output logic req_ready, // queue accepts the access
    input wire logic wait_exec, // core executes the wait instruction
    input wire logic instr_done, // core finishes an instruction
    input wire logic irq_mask, // interrupt mask bit of the core
    output logic irq_take, // pulse: maskable interrupt accepted
    output logic rd_valid, // pulse: read data ready
    output logic [bus_ctl_pkg::DATA_W-1:0] rd_data, // read data
    input wire logic run_halt_n, // pin, low requests halt
    input wire logic irq_n, // pin, maskable interrupt request
    input wire logic restart_n, // pin, restart control
    input wire logic abort_n, // pin, abort control
    input wire logic tristate_request, // pin, float address lines
    input wire logic slow_memory_ready, // pin, low stretches access
    input wire logic power_fail, // pin, supply monitor alarm
    input wire logic [bus_ctl_pkg::DATA_W-1:0] data_line_in, // data pins sensed
    output bus_ctl_pkg::bp_out_t bp // registered backplane outputs
);
    import bus_ctl_pkg::*;

    logic rst_meta_r, rstn_s;
    logic [PIN_CNT-1:0] pin_raw, pin_meta_r, pin_s;
    logic [DATA_W-1:0] data_meta_r, data_s;
    logic run_s, irq_s_n, restart_s_n, abort_s_n, tsc_s, ready_s, pfail_s;

    // reset release through two flip-flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_r <= 1'b0;
            rstn_s <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rstn_s <= rst_meta_r;
        end
    end

    assign pin_raw = {power_fail, slow_memory_ready, tristate_request, abort_n,
                      restart_n, irq_n, run_halt_n};

    // two-stage synchronisers for every pin
    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++)
        begin : g_pin_sync
            always_ff @(posedge clock or negedge rstn_s)
            begin
                if (!rstn_s)
                begin
                    pin_meta_r[gi] <= PIN_RESET[gi];
                    pin_s[gi] <= PIN_RESET[gi];
                end
                else
                begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_s[gi] <= pin_meta_r[gi];
                end
            end
        end
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_data_sync
            always_ff @(posedge clock or negedge rstn_s)
            begin
                if (!rstn_s)
                begin
                    data_meta_r[gi] <= 1'b0;
                    data_s[gi] <= 1'b0;
                end
                else
                begin
                    data_meta_r[gi] <= data_line_in[gi];
                    data_s[gi] <= data_meta_r[gi];
                end
            end
        end
    endgenerate

    assign run_s = pin_s[PIN_RUN_HALT_N];
    assign irq_s_n = pin_s[PIN_IRQ_N];
    assign restart_s_n = pin_s[PIN_RESTART_N];
    assign abort_s_n = pin_s[PIN_ABORT_N];
    assign tsc_s = pin_s[PIN_TSC];
    assign ready_s = pin_s[PIN_READY];
    assign pfail_s = pin_s[PIN_PFAIL];

    // request queue in the data path
    logic fifo_valid, fifo_pop;
    logic [REQ_W-1:0] fifo_word;

    req_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(DEPTH)
    ) u_req_fifo (
        .clock(clock),
        .rstn_s(rstn_s),
        .in_valid(req_valid),
        .in_data(req),
        .in_ready(req_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_word),
        .out_ready(fifo_pop)
    );

    run_state_t state_r, state_nxt;
    logic irq_take_r, irq_take_nxt, irq_ok;

    assign irq_ok = !irq_s_n && !irq_mask; // see [R14]

    // run, wait and halt sequencing
    always_comb
    begin
        state_nxt = state_r;
        irq_take_nxt = 1'b0;
        case (state_r)
            ST_RUN:
            begin
                if (!run_s)
                begin
                    state_nxt = ST_HALT; // see [R2]
                end
                else if (wait_exec)
                begin
                    state_nxt = ST_WAIT; // see [R3]
                end
                else if (instr_done && irq_ok)
                begin
                    irq_take_nxt = 1'b1; // see [R14]
                end
            end
            ST_WAIT:
            begin
                if (!run_s)
                begin
                    state_nxt = ST_HALT;
                end
                else if (irq_ok)
                begin
                    state_nxt = ST_RUN; // see [R5]
                    irq_take_nxt = 1'b1;
                end
                else if (!restart_s_n || !abort_s_n)
                begin
                    state_nxt = ST_RUN; // see [R5]
                end
            end
            ST_HALT:
            begin
                if (run_s)
                begin
                    state_nxt = ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn_s)
    begin
        if (!rstn_s)
        begin
            state_r <= ST_HALT;
            irq_take_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            irq_take_r <= irq_take_nxt;
        end
    end

    assign irq_take = irq_take_r;

    // phase generator and bus cycle engine
    bp_out_t bp_r, bp_nxt;
    bus_req_t cyc_r, cyc_nxt;
    logic cyc_act_r, cyc_act_nxt;
    logic phase_nxt, start, owned_nxt;
    logic [1:0] cap_r, cap_nxt;
    logic rd_valid_r, rd_valid_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;

    assign start = bp_r.phi2 && ready_s; // see [R15]
    assign owned_nxt = (state_nxt == ST_RUN) && !tsc_s;
    assign fifo_pop = start && owned_nxt && fifo_valid;

    always_comb
    begin
        bp_nxt = bp_r;
        // phase two held while ready is low
        phase_nxt = bp_r.phi2 ? !ready_s : 1'b1; // see [R6]
        bp_nxt.phi2 = phase_nxt;
        bp_nxt.phi1 = !phase_nxt;
        cyc_act_nxt = start ? fifo_pop : (cyc_act_r && owned_nxt);
        cyc_nxt = fifo_pop ? bus_req_t'(fifo_word) : cyc_r;
        // release indication and driver control
        bp_nxt.bus_released = (state_nxt != ST_RUN) && !tsc_s; // see [R1]
        bp_nxt.addr_oe_n = !owned_nxt; // see [R4]
        bp_nxt.address_valid = cyc_act_nxt; // see [R13]
        bp_nxt.addr = cyc_nxt.addr;
        bp_nxt.data = cyc_nxt.data;
        bp_nxt.data_oe_n = !(cyc_act_nxt && !cyc_nxt.rd && phase_nxt); // see [R11]
        bp_nxt.power_good_line = !pfail_s; // see [R10]
        // read data sampled at the end of phase two, after the pin delay
        cap_nxt = {cap_r[0], start && cyc_act_r && cyc_r.rd};
        rd_valid_nxt = cap_r[1];
        rd_data_nxt = cap_r[1] ? data_s : rd_data_r; // see [R11]
    end

    always_ff @(posedge clock or negedge rstn_s)
    begin
        if (!rstn_s)
        begin
            bp_r <= BP_OUT_RESET;
            cyc_r <= REQ_RESET;
            cyc_act_r <= 1'b0;
            cap_r <= 2'h0;
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end
        else
        begin
            bp_r <= bp_nxt;
            cyc_r <= cyc_nxt;
            cyc_act_r <= cyc_act_nxt;
            cap_r <= cap_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign bp = bp_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;

    logic address_valid_w;
    assign address_valid_w = bp.address_valid;

    // checks on the release, wait and clock behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn_s);

    chk_released_stopped: assert property (bp.bus_released |-> state_r != ST_RUN) // see [R1]
        else $error("bus released while running");
    chk_halt_release: assert property (!run_s && !tsc_s |=> bp.bus_released) // see [R2]
        else $error("halt did not release the bus");
    chk_wait_release: assert property (
        state_r == ST_RUN && run_s && wait_exec && !tsc_s |=> bp.bus_released) // see [R3]
        else $error("wait did not release the bus");
    chk_released_drivers: assert property (
        bp.bus_released |-> bp.addr_oe_n && bp.data_oe_n && !bp.address_valid) // see [R4]
        else $error("driver active while bus released");
    chk_wait_exit: assert property (
        state_r == ST_WAIT && run_s && (!restart_s_n || !abort_s_n || irq_ok)
        |=> state_r == ST_RUN) // see [R5]
        else $error("wait state not left");
    chk_stretch_hold: assert property (
        bp.phi2 && !ready_s ##1 !ready_s |=> bp.phi2 && !bp.phi1) // see [R6]
        else $error("phase two not held while ready low");
    chk_standby_line: assert property (pfail_s |=> !bp.power_good_line) // see [R10]
        else $error("standby line high during power fail");
    chk_data_drive: assert property (!bp.data_oe_n |-> bp.phi2 && address_valid_w) // see [R11]
        else $error("data driven outside a write phase two");
    chk_tristate_req: assert property (
        tsc_s |=> bp.addr_oe_n && !bp.address_valid && !bp.bus_released) // see [R13]
        else $error("tristate request not honoured");
    chk_irq_mask: assert property (irq_take |-> !$past(irq_mask) && !$past(irq_s_n)) // see [R14]
        else $error("interrupt taken while masked");
    chk_ready_resume: assert property (bp.phi2 && ready_s |=> bp.phi1 ##1 bp.phi2) // see [R15]
        else $error("phases did not resume after ready");

endmodule : backplane_bus_control

// file: common/bus_ctl_pkg.sv
// shared constants and types of the processor-side backplane bus control
package bus_ctl_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // bit positions inside the synchronised pin vector
    localparam int PIN_RUN_HALT_N = 0;
    localparam int PIN_IRQ_N = 1;
    localparam int PIN_RESTART_N = 2;
    localparam int PIN_ABORT_N = 3;
    localparam int PIN_TSC = 4;
    localparam int PIN_READY = 5;
    localparam int PIN_PFAIL = 6;
    localparam int PIN_CNT = 7;

    // values after reset of the pin synchronisers (pins idle / inactive)
    localparam logic [PIN_CNT-1:0] PIN_RESET = 7'h2f;

    // one queued bus access from the processor core
    typedef struct packed {
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_req_t;

    localparam int REQ_W = $bits(bus_req_t);
    localparam bus_req_t REQ_RESET = '0;

    // processor run state as seen from the backplane
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WAIT = 2'b01,
        ST_HALT = 2'b10
    } run_state_t;

    // backplane output pins, all registered
    typedef struct packed {
        logic bus_released;
        logic address_valid;
        logic addr_oe_n;
        logic [ADDR_W-1:0] addr;
        logic data_oe_n;
        logic [DATA_W-1:0] data;
        logic phi1;
        logic phi2;
        logic power_good_line;
    } bp_out_t;

    // values after reset: bus released, drivers off, phase one
    localparam bp_out_t BP_OUT_RESET = '{
        bus_released: 1'b1,
        address_valid: 1'b0,
        addr_oe_n: 1'b1,
        addr: '0,
        data_oe_n: 1'b1,
        data: '0,
        phi1: 1'b1,
        phi2: 1'b0,
        power_good_line: 1'b0
    };

endpackage : bus_ctl_pkg

// file: logic/req_fifo.sv
// request queue between the processor core and the backplane cycle engine
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 8, // word width
    parameter int DEPTH = 16 // number of words
) (
    input wire logic clock, // system clock
    input wire logic rstn_s, // synchronised reset, active low
    input wire logic in_valid, // word offered
    input wire logic [WIDTH-1:0] in_data, // offered word
    output logic in_ready, // room for a word
    output logic out_valid, // word available
    output logic [WIDTH-1:0] out_data, // oldest word
    input wire logic out_ready // drain takes the word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] count_r, count_nxt;
    logic room_r, room_nxt;
    logic push, pop;

    assign push = in_valid && room_r;
    assign pop = out_ready && (count_r != '0);
    assign in_ready = room_r; // straight from a flip-flop
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];

    // pointer and fill level update
    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push)
        begin
            wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : PW'(wr_ptr_r + 1'b1);
        end
        if (pop)
        begin
            rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : PW'(rd_ptr_r + 1'b1);
        end
        if (push && !pop)
        begin
            count_nxt = CW'(count_r + 1'b1);
        end
        else if (pop && !push)
        begin
            count_nxt = CW'(count_r - 1'b1);
        end
        room_nxt = (count_nxt != FULL_CNT);
    end

    // pointer, fill level and room registers
    always_ff @(posedge clock or negedge rstn_s)
    begin
        if (!rstn_s)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            room_r <= 1'b1;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            room_r <= room_nxt;
        end
    end

    // word storage, no reset needed
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

endmodule : req_fifo

// file: bench/slow_mem.sv
// slow memory module on the backplane: stretches accesses, answers reads
`timescale 1ns/1ps
module slow_mem
    import bus_ctl_pkg::*;
(
    input wire logic clock, // system clock
    input wire bus_ctl_pkg::bp_out_t bp, // processor outputs
    input wire logic [3:0] stall, // ready-low cycles per access
    output logic slow_memory_ready, // ready pin
    output logic [bus_ctl_pkg::DATA_W-1:0] data_line_in // data pins
);
    logic [3:0] busy = 4'h0;
    logic [1:0] hold = 2'h0;
    logic [7:0] noise = 8'h00;
    logic [15:0] a_r = 16'h0000;
    logic sel;
    // selected only in phase two of a read, processor not driving
    assign sel = bp.address_valid && bp.phi2 && bp.data_oe_n;
    // drive while selected or holding, else a pattern that keeps changing
    assign data_line_in = (sel || hold != 2'h0) ?
        ((sel ? bp.addr[7:0] : a_r[7:0]) ^ 8'h5a) : noise;
    assign slow_memory_ready = (busy == 4'h0);
    // refresh master on this card pulses the trigger, the slave part starts a refresh
    logic [5:0] ref_cnt = 6'h00;
    logic refresh_trigger;
    logic [1:0] refresh_busy = 2'h0;
    assign refresh_trigger = (ref_cnt == 6'h3f);
    always @(posedge clock)
    begin
        ref_cnt <= ref_cnt + 6'h01;
        if (refresh_trigger)
            refresh_busy <= 2'h3;
        else if (refresh_busy != 2'h0)
            refresh_busy <= refresh_busy - 2'h1;
    end
    // busy count per access, data hold after phase two
    always @(posedge clock)
    begin
        if (bp.address_valid && bp.phi1 && busy == 4'h0 && stall != 4'h0)
            busy <= stall;
        else if (busy != 4'h0)
            busy <= busy - 4'h1;
        hold <= sel ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
        a_r <= sel ? bp.addr : a_r;
        noise <= noise + 8'h3b;
    end
endmodule : slow_mem

// file: bench/test_backplane_bus_control.sv
// self-checking bench for the processor-side backplane bus control
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_backplane_bus_control;
    import bus_ctl_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    bus_req_t req = REQ_RESET;
    logic wait_exec = 1'b0, instr_done = 1'b0, irq_mask = 1'b1;
    logic run_halt_n = 1'b1, irq_n = 1'b1, restart_n = 1'b1, abort_n = 1'b1;
    logic tristate_request = 1'b0, power_fail = 1'b0;
    logic [3:0] stall = 4'h0;
    logic req_ready, irq_take, rd_valid, slow_memory_ready;
    logic [DATA_W-1:0] rd_data, data_line_in;
    bp_out_t bp;
    int failures = 0;
    int n_compared = 0;

    backplane_bus_control dut_u (.clock, .rstn, .req_valid, .req, .req_ready,
        .wait_exec, .instr_done, .irq_mask, .irq_take, .rd_valid, .rd_data,
        .run_halt_n, .irq_n, .restart_n, .abort_n, .tristate_request,
        .slow_memory_ready, .power_fail, .data_line_in, .bp);
    slow_mem mem_u (.clock, .bp, .stall, .slow_memory_ready, .data_line_in);

    // free-running 50 MHz clock
    initial
    begin
        forever #10 clock = ~clock;
    end

    task tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    // offer one word, hold it until the queue takes it
    task push(input logic rd, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clock);
        req_valid = 1'b1;
        req = '{rd: rd, addr: a, data: d};
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        req_valid = 1'b0;
    endtask : push

    // look for a one-cycle pulse of irq_take or rd_valid
    task wait_pulse(input bit rd, output bit seen);
        seen = 1'b0;
        repeat (40)
        begin
            @(negedge clock);
            if ((rd ? rd_valid : irq_take) === 1'b1)
            begin
                seen = 1'b1;
                break;
            end
        end
    endtask : wait_pulse

    task t_write;
        int n;
        n = 0;
        push(1'b0, 16'h1234, 8'ha5);
        while (!(bp.phi2 && !bp.data_oe_n) && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        `CHECK({bp.address_valid, bp.addr, bp.data}, {1'b1, 16'h1234, 8'ha5})
        `CHECK(bp.bus_released, 1'b0)
    endtask : t_write

    // read with the memory stretching phase two by s cycles
    task t_read(input logic [3:0] s);
        int run, mx;
        bit seen;
        run = 0;
        mx = 0;
        seen = 1'b0;
        stall = s;
        push(1'b1, {12'h40c, s}, 8'h00);
        repeat (30)
        begin
            @(negedge clock);
            run = bp.phi2 ? run + 1 : 0;
            mx = run > mx ? run : mx;
            if (rd_valid === 1'b1)
                seen = 1'b1;
        end
        `CHECK(seen, 1'b1)
        `CHECK(rd_data, {4'hc, s} ^ 8'h5a)
        if (s == 4'h0)
            `CHECK(mx, 1)
        else
            `CHECK(mx > 1 && mx <= int'(s) + 4, 1'b1)
        stall = 4'h0;
    endtask : t_read

    // halt, fill the queue until refused, then drain with a stalling memory
    task t_halt_fill;
        int n;
        bit p;
        run_halt_n = 1'b0;
        tick(4);
        `CHECK(bp.bus_released, 1'b1)
        `CHECK({bp.addr_oe_n, bp.data_oe_n, bp.address_valid}, 3'b110)
        for (int i = 0; i < 16; i++)
            push(1'b0, 16'h0100 + 16'(i), 8'(i));
        `CHECK(req_ready, 1'b0)
        n = 0;
        p = 1'b0;
        stall = 4'h2;
        run_halt_n = 1'b1;
        repeat (300)
        begin
            @(negedge clock);
            if (bp.phi2 && !bp.data_oe_n && !p)
                n++;
            p = bp.phi2 && !bp.data_oe_n;
        end
        `CHECK(n, 16)
        `CHECK(req_ready, 1'b1)
        stall = 4'h0;
    endtask : t_halt_fill

    // enter the wait state, leave by interrupt (0), restart (1) or abort (2)
    task t_wait(input int k);
        bit seen;
        @(negedge clock);
        wait_exec = 1'b1;
        @(negedge clock);
        wait_exec = 1'b0;
        tick(2);
        `CHECK(bp.bus_released, 1'b1)
        `CHECK({bp.addr_oe_n, bp.address_valid}, 2'b10)
        if (k == 0)
        begin
            irq_n = 1'b0;
            tick(6);
            `CHECK(bp.bus_released, 1'b1)
            irq_mask = 1'b0;
            wait_pulse(1'b0, seen);
            `CHECK(seen, 1'b1)
        end
        else if (k == 1)
            restart_n = 1'b0;
        else
            abort_n = 1'b0;
        tick(5);
        `CHECK(bp.bus_released, 1'b0)
        {irq_n, restart_n, abort_n, irq_mask} = 4'hf;
        tick(4);
    endtask : t_wait

    // interrupt while running: only at an instruction end, only unmasked
    task t_irq_run;
        bit seen;
        irq_mask = 1'b0;
        irq_n = 1'b0;
        wait_pulse(1'b0, seen);
        `CHECK(seen, 1'b0)
        for (int m = 1; m >= 0; m--)
        begin
            irq_mask = m[0];
            @(negedge clock);
            instr_done = 1'b1;
            @(negedge clock);
            instr_done = 1'b0;
            seen = irq_take === 1'b1;
            if (!seen)
                wait_pulse(1'b0, seen);
            `CHECK(seen, m == 0)
        end
        {irq_n, irq_mask} = 2'b11;
    endtask : t_irq_run

    task t_tsc;
        tristate_request = 1'b1;
        tick(4);
        `CHECK({bp.addr_oe_n, bp.address_valid, bp.bus_released}, 3'b100)
        run_halt_n = 1'b0;
        tick(4);
        `CHECK(bp.bus_released, 1'b0)
        {tristate_request, run_halt_n} = 2'b01;
        tick(4);
        `CHECK({bp.addr_oe_n, bp.bus_released}, 2'b00)
    endtask : t_tsc

    task t_power;
        power_fail = 1'b1;
        tick(4);
        `CHECK(bp.power_good_line, 1'b0)
        power_fail = 1'b0;
        tick(4);
        `CHECK(bp.power_good_line, 1'b1)
    endtask : t_power

    task finish_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        $display("BAD t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        finish_test;
    end

    // main sequence
    initial
    begin
        tick(16);
        `CHECK(bp, BP_OUT_RESET)
        rstn = 1'b1;
        tick(6);
        `CHECK(bp.bus_released, 1'b0)
        `CHECK(bp.power_good_line, 1'b1)
        t_write;
        t_read(4'h0);
        t_read(4'h5);
        t_halt_fill;
        for (int k = 0; k < 3; k++)
            t_wait(k);
        t_irq_run;
        t_tsc;
        t_power;
        finish_test;
    end
endmodule : test_backplane_bus_control
